// ==== rtl/audio_port_pin_routing.sv ====
// routing of multipurpose pins to the secondary serial port and pdm record channels
//
// What this block does
// - primary serial input data passes only while its enable bit is one; resets one
// - frame sync source: 0 off, 1-3 general pins, 5 primary frame sync
// - bit clock source: 0 off, 1-3 general pins, 5 primary bit clock
// - reserved bits read zero; writes to them are dropped
// - data source: 0 off, 1-3 general pins, 4 serial output, 5 primary data
// - second data source uses the same encoding as the first
// - record channel one is pdm only while its type bit is one
// - record channel two is pdm only while its type bit is one
// - first line edge bit swaps which pdm clock edge feeds channels one, two
// - second line edge bit swaps which pdm clock edge feeds channels three, four
// - first pdm line source: 0 off, 1-3 general pins
// - second pdm line source: 0 off, 1-3 general pins
// - secondary port stays inactive while its disable input is one
`timescale 1ns/1ps
`include "pin_routing_defines.svh"

module audio_port_pin_routing (
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // secondary port disable level from the serial port control
  input wire logic secondary_port_disable,
  // multipurpose pins
  input wire logic general_pin_one,
  input wire logic general_pin_two,
  input wire logic general_input_pin,
  input wire logic serial_output_pin,
  input wire logic pdm_clock_pin,
  // primary serial port pins
  input wire logic primary_frame_sync_pin,
  input wire logic primary_bit_clock_pin,
  input wire logic primary_data_pin,
  // routed primary data
  output logic primary_data,
  // routed secondary serial port signals
  output logic secondary_port_active,
  output logic secondary_frame_sync,
  output logic secondary_bit_clock,
  output logic secondary_data,
  output logic secondary_second_data,
  // pdm record channels, bit and one-cycle valid per channel
  output logic [3:0] pdm_bit,
  output logic [3:0] pdm_valid
);

  // ----------------------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------------------
  localparam int PIN_COUNT = 8;

  logic [PIN_COUNT-1:0] raw_pins;
  logic [PIN_COUNT-1:0] sync_pins;
  logic pin_one_s;
  logic pin_two_s;
  logic input_pin_s;
  logic serial_out_s;
  logic pdm_clock_s;
  logic frame_sync_s;
  logic bit_clock_s;
  logic data_s;

  // pins gathered so one synchroniser instance covers them all
  assign raw_pins = {primary_data_pin, primary_bit_clock_pin, primary_frame_sync_pin,
                     pdm_clock_pin, serial_output_pin, general_input_pin,
                     general_pin_two, general_pin_one};

  pin_sync #(
    .WIDTH(PIN_COUNT)
  ) u_pin_sync (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .pin_in(raw_pins),
    .pin_out(sync_pins)
  );

  assign pin_one_s = sync_pins[0];
  assign pin_two_s = sync_pins[1];
  assign input_pin_s = sync_pins[2];
  assign serial_out_s = sync_pins[3];
  assign pdm_clock_s = sync_pins[4];
  assign frame_sync_s = sync_pins[5];
  assign bit_clock_s = sync_pins[6];
  assign data_s = sync_pins[7];

  // the disable level comes from logic on this clock, so it is read directly

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  pin_routing_pkg::routing_state_s state;
  pin_routing_pkg::routing_state_s next_state;

  // ----------------------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------------------
  // any unlisted code falls to zero so a reserved setting routes nothing
  function automatic logic pick_source(
    input logic [2:0] code,
    input logic allow_serial_out,
    input logic primary_level
  );
    logic result;
    result = 1'b0;
    unique case (code)
      `SRC_PIN_ONE: result = pin_one_s;
      `SRC_PIN_TWO: result = pin_two_s;
      `SRC_INPUT_PIN: result = input_pin_s;
      `SRC_SERIAL_OUT: result = allow_serial_out & serial_out_s;
      `SRC_PRIMARY: result = primary_level;
      default: result = 1'b0;
    endcase
    return result;
  endfunction : pick_source

  logic [2:0] frame_sync_code;
  logic [2:0] bit_clock_code;
  logic [2:0] data_one_code;
  logic [2:0] data_two_code;
  logic [1:0] first_line_code;
  logic [1:0] second_line_code;
  logic first_line_data;
  logic second_line_data;
  logic first_line_on;
  logic second_line_on;
  logic clocks_selected;

  // field extraction from the stored registers
  always_comb begin
    frame_sync_code = state.secondary_port_clock_source[`FLD_FRAME_SYNC_HI:`FLD_FRAME_SYNC_LO];
    bit_clock_code = state.secondary_port_clock_source[`FLD_BIT_CLOCK_HI:`FLD_BIT_CLOCK_LO];
    data_one_code = state.secondary_port_data_source[`FLD_DATA_ONE_HI:`FLD_DATA_ONE_LO];
    data_two_code = state.secondary_port_data_source[`FLD_DATA_TWO_HI:`FLD_DATA_TWO_LO];
    first_line_code = state.pdm_input_routing[`FLD_FIRST_LINE_HI:`FLD_FIRST_LINE_LO];
    second_line_code = state.pdm_input_routing[`FLD_SECOND_LINE_HI:`FLD_SECOND_LINE_LO];
  end

  // pdm line sources; code zero leaves the line off and quiet
  always_comb begin
    first_line_on = (first_line_code != 2'h0);
    second_line_on = (second_line_code != 2'h0);
    first_line_data = pick_source({1'b0, first_line_code}, 1'b0, 1'b0);
    second_line_data = pick_source({1'b0, second_line_code}, 1'b0, 1'b0);
  end

  // the port needs both clock sources on legal codes; a code of zero or a
  // reserved code on either one disables the whole secondary port
  always_comb begin
    clocks_selected = 1'b1;
    unique case (frame_sync_code)
      `SRC_PIN_ONE, `SRC_PIN_TWO, `SRC_INPUT_PIN, `SRC_PRIMARY: clocks_selected = 1'b1;
      default: clocks_selected = 1'b0;
    endcase
    unique case (bit_clock_code)
      `SRC_PIN_ONE, `SRC_PIN_TWO, `SRC_INPUT_PIN, `SRC_PRIMARY: begin
        clocks_selected = clocks_selected;
      end
      default: clocks_selected = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------------
  // pdm capture, one instance per data line
  // ----------------------------------------------------------------------------
  logic [3:0] cap_bit;
  logic [3:0] cap_valid;

  pdm_edge_capture u_first_line (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .pdm_clock(pdm_clock_s),
    .pdm_data(first_line_data),
    .line_enable(first_line_on),
    .edge_select(state.pdm_input_routing[`BIT_FIRST_LINE_EDGE]),
    .first_bit(cap_bit[0]),
    .first_valid(cap_valid[0]),
    .second_bit(cap_bit[1]),
    .second_valid(cap_valid[1])
  );

  pdm_edge_capture u_second_line (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .pdm_clock(pdm_clock_s),
    .pdm_data(second_line_data),
    .line_enable(second_line_on),
    .edge_select(state.pdm_input_routing[`BIT_SECOND_LINE_EDGE]),
    .first_bit(cap_bit[2]),
    .first_valid(cap_valid[2]),
    .second_bit(cap_bit[3]),
    .second_valid(cap_valid[3])
  );

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  logic port_on;
  logic [3:0] channel_type;

  always_comb begin
    next_state = state;

    // register writes keep reserved bits at zero
    if (reg_write) begin
      unique case (reg_addr)
        `OFS_CLOCK_SOURCE: begin
          next_state.secondary_port_clock_source = reg_wdata & `MASK_CLOCK_SOURCE;
        end
        `OFS_DATA_SOURCE: begin
          next_state.secondary_port_data_source = reg_wdata & `MASK_DATA_SOURCE;
        end
        `OFS_PDM_ROUTING: begin
          next_state.pdm_input_routing = reg_wdata & `MASK_PDM_ROUTING;
        end
        `OFS_CONFIG_FIVE: begin
          next_state.interface_config_five = reg_wdata & `MASK_CONFIG_FIVE;
        end
        default: begin
          next_state.interface_config_five = state.interface_config_five; // unmapped
        end
      endcase
    end

    // read data is captured on the read strobe; unmapped offsets read zero
    if (reg_read) begin
      unique case (reg_addr)
        `OFS_CLOCK_SOURCE: next_state.reg_rdata = state.secondary_port_clock_source;
        `OFS_DATA_SOURCE: next_state.reg_rdata = state.secondary_port_data_source;
        `OFS_PDM_ROUTING: next_state.reg_rdata = state.pdm_input_routing;
        `OFS_CONFIG_FIVE: next_state.reg_rdata = state.interface_config_five;
        default: next_state.reg_rdata = 8'h00;
      endcase
    end

    // primary data follows its pin only while enabled, else held low
    next_state.primary_data = state.secondary_port_clock_source[`BIT_PRIMARY_INPUT_ENABLE]
                              & data_s;

    // secondary port runs only when enabled and both clocks have a source
    port_on = ~secondary_port_disable & clocks_selected;
    next_state.secondary_port_active = port_on;
    next_state.secondary_frame_sync = port_on
                                      & pick_source(frame_sync_code, 1'b0, frame_sync_s);
    next_state.secondary_bit_clock = port_on
                                     & pick_source(bit_clock_code, 1'b0, bit_clock_s);
    // data routing; primary choice follows the primary enable gate
    next_state.secondary_data = port_on
      & pick_source(data_one_code, 1'b1, next_state.primary_data);
    next_state.secondary_second_data = port_on
      & pick_source(data_two_code, 1'b1, next_state.primary_data);

    // channels one and two pass only when typed as pdm; three, four always
    channel_type = {2'b11,
                    state.pdm_input_routing[`BIT_CHANNEL_TWO_TYPE],
                    state.pdm_input_routing[`BIT_CHANNEL_ONE_TYPE]};
    next_state.pdm_bit = cap_bit & channel_type;
    next_state.pdm_valid = cap_valid & channel_type;
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= '0;
      state.secondary_port_clock_source <= `RST_CLOCK_SOURCE;
      state.secondary_port_data_source <= `RST_DATA_SOURCE;
      state.pdm_input_routing <= `RST_PDM_ROUTING;
      state.interface_config_five <= `RST_CONFIG_FIVE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs straight from the state flops
  // ----------------------------------------------------------------------------
  assign reg_rdata = state.reg_rdata;
  assign primary_data = state.primary_data;
  assign secondary_port_active = state.secondary_port_active;
  assign secondary_frame_sync = state.secondary_frame_sync;
  assign secondary_bit_clock = state.secondary_bit_clock;
  assign secondary_data = state.secondary_data;
  assign secondary_second_data = state.secondary_second_data;
  assign pdm_bit = state.pdm_bit;
  assign pdm_valid = state.pdm_valid;

endmodule : audio_port_pin_routing

// ==== shared/pin_routing_defines.svh ====
// offsets, field positions, reset values and select codes of the pin routing registers
`ifndef PIN_ROUTING_DEFINES_SVH
`define PIN_ROUTING_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define OFS_CLOCK_SOURCE 8'h11
`define OFS_DATA_SOURCE 8'h12
`define OFS_PDM_ROUTING 8'h13
`define OFS_CONFIG_FIVE 8'h14

// ----------------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------------
`define RST_CLOCK_SOURCE 8'h80
`define RST_DATA_SOURCE 8'h00
`define RST_PDM_ROUTING 8'h00
`define RST_CONFIG_FIVE 8'h00
`define MASK_CLOCK_SOURCE 8'hFE
`define MASK_DATA_SOURCE 8'hFC
`define MASK_PDM_ROUTING 8'hFF
`define MASK_CONFIG_FIVE 8'hFF

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define BIT_PRIMARY_INPUT_ENABLE 7
`define FLD_FRAME_SYNC_HI 6
`define FLD_FRAME_SYNC_LO 4
`define FLD_BIT_CLOCK_HI 3
`define FLD_BIT_CLOCK_LO 1
`define FLD_DATA_ONE_HI 7
`define FLD_DATA_ONE_LO 5
`define FLD_DATA_TWO_HI 4
`define FLD_DATA_TWO_LO 2
`define BIT_CHANNEL_ONE_TYPE 7
`define BIT_CHANNEL_TWO_TYPE 6
`define BIT_FIRST_LINE_EDGE 5
`define BIT_SECOND_LINE_EDGE 4
`define FLD_FIRST_LINE_HI 3
`define FLD_FIRST_LINE_LO 2
`define FLD_SECOND_LINE_HI 1
`define FLD_SECOND_LINE_LO 0

// ----------------------------------------------------------------------------
// source select codes
// ----------------------------------------------------------------------------
`define SRC_OFF 3'h0
`define SRC_PIN_ONE 3'h1
`define SRC_PIN_TWO 3'h2
`define SRC_INPUT_PIN 3'h3
`define SRC_SERIAL_OUT 3'h4
`define SRC_PRIMARY 3'h5

`endif

// ==== shared/pin_routing_pkg.sv ====
// state types shared by the pin routing modules
package pin_routing_pkg;

  // ----------------------------------------------------------------------------
  // pdm capture state
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic clock_prev;
    logic first_bit;
    logic first_valid;
    logic second_bit;
    logic second_valid;
  } capture_state_s;

  // ----------------------------------------------------------------------------
  // routing block state
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] secondary_port_clock_source;
    logic [7:0] secondary_port_data_source;
    logic [7:0] pdm_input_routing;
    logic [7:0] interface_config_five;
    logic [7:0] reg_rdata;
    logic primary_data;
    logic secondary_frame_sync;
    logic secondary_bit_clock;
    logic secondary_data;
    logic secondary_second_data;
    logic secondary_port_active;
    logic [3:0] pdm_bit;
    logic [3:0] pdm_valid;
  } routing_state_s;

endpackage : pin_routing_pkg

// ==== rtl/pin_sync.sv ====
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 8
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // asynchronous pins in, synchronised levels out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] stage_one;

  // ----------------------------------------------------------------------------
  // per-bit flop pair; the first stage feeds only the second
  // ----------------------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clock) begin
      if (rst) begin
        stage_one[i] <= 1'b0;
        pin_out[i] <= 1'b0;
      end else if (ce) begin
        stage_one[i] <= pin_in[i];
        pin_out[i] <= stage_one[i];
      end
    end
  end

endmodule : pin_sync

// ==== rtl/pdm_edge_capture.sv ====
// latches one pdm data line on both pdm clock edges into two channels
`timescale 1ns/1ps

module pdm_edge_capture (
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // synchronised pdm clock and data, line configuration
  input wire logic pdm_clock,
  input wire logic pdm_data,
  input wire logic line_enable,
  input wire logic edge_select,
  // captured channels, valid pulses one cycle long
  output logic first_bit,
  output logic first_valid,
  output logic second_bit,
  output logic second_valid
);

  pin_routing_pkg::capture_state_s state;
  pin_routing_pkg::capture_state_s next_state;

  logic rise;
  logic fall;
  logic first_edge;
  logic second_edge;

  // ----------------------------------------------------------------------------
  // edge detect on the synchronised clock; edge_select swaps the channel edges
  // ----------------------------------------------------------------------------
  always_comb begin
    rise = pdm_clock & ~state.clock_prev;
    fall = ~pdm_clock & state.clock_prev;
    first_edge = edge_select ? rise : fall;
    second_edge = edge_select ? fall : rise;
    next_state = state;
    next_state.clock_prev = pdm_clock;
    next_state.first_valid = line_enable & first_edge;
    next_state.second_valid = line_enable & second_edge;
    if (line_enable && first_edge) begin
      next_state.first_bit = pdm_data;
    end
    if (line_enable && second_edge) begin
      next_state.second_bit = pdm_data;
    end
    if (!line_enable) begin
      next_state.first_bit = 1'b0; // quiet level while the line is off
      next_state.second_bit = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign first_bit = state.first_bit;
  assign first_valid = state.first_valid;
  assign second_bit = state.second_bit;
  assign second_valid = state.second_valid;

endmodule : pdm_edge_capture

// ==== verif/routing_monitor.sv ====
// concurrent checks on the pin routing block ports
`timescale 1ns/1ps

module routing_monitor (
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // port disable input and routed outputs
  input wire logic secondary_port_disable,
  input wire logic primary_data,
  input wire logic secondary_port_active,
  input wire logic secondary_frame_sync,
  input wire logic secondary_bit_clock,
  input wire logic secondary_data,
  input wire logic secondary_second_data,
  input wire logic [3:0] pdm_valid
);
  // ----------------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // one register read request
  sequence s_rd(logic [7:0] a);
    ce && reg_read && reg_addr == a;
  endsequence
  // a clock source read in the first cycle after reset release
  sequence s_first_read;
    $fell(rst) ##0 s_rd(8'h11);
  endsequence

  AST_RESET_READ: assert property (s_first_read |=> reg_rdata == 8'h80)
    else $error("clock source reset value wrong");
  AST_RESET_QUIET: assert property ($fell(rst) |-> !secondary_port_active && !primary_data)
    else $error("outputs not quiet after reset");
  AST_DISABLE_INACTIVE: assert property (ce && secondary_port_disable |=> !secondary_port_active)
    else $error("secondary port active while disabled");
  AST_INACTIVE_QUIET: assert property (!secondary_port_active |-> !(secondary_frame_sync
    || secondary_bit_clock || secondary_data || secondary_second_data))
    else $error("secondary signal routed while port inactive");
  AST_VALID_PULSE: assert property (pdm_valid != 4'h0 |=> (pdm_valid & $past(pdm_valid)) == 4'h0)
    else $error("pdm valid longer than one cycle");
  AST_PAIR_EXCLUSIVE: assert property (pdm_valid != 4'h0 |->
    !(pdm_valid[0] && pdm_valid[1]) && !(pdm_valid[2] && pdm_valid[3]))
    else $error("both channels of one line latched on one edge");
  AST_RSV_CLOCK_REG: assert property (s_rd(8'h11) |=> !reg_rdata[0])
    else $error("reserved clock source bit reads one");
  AST_RSV_DATA_REG: assert property (s_rd(8'h12) |=> reg_rdata[1:0] == 2'b00)
    else $error("reserved data source bits read nonzero");
  AST_UNMAPPED_ZERO: assert property (ce && reg_read && !(reg_addr inside {[8'h11:8'h14]})
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : routing_monitor

bind audio_port_pin_routing routing_monitor mon_u (.clock(clock), .rst(rst), .ce(ce),
  .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .secondary_port_disable(secondary_port_disable), .primary_data(primary_data),
  .secondary_port_active(secondary_port_active), .secondary_frame_sync(secondary_frame_sync),
  .secondary_bit_clock(secondary_bit_clock), .secondary_data(secondary_data),
  .secondary_second_data(secondary_second_data), .pdm_valid(pdm_valid));

// ==== verif/pin_partner.sv ====
// far side model: host serial port pins and pdm microphones
`timescale 1ns/1ps

module pin_partner (
  // clock, reset, pdm clock run request
  input wire logic clock,
  input wire logic rst,
  input wire logic pdm_run,
  // pins toward the device
  output logic [6:0] pins,
  output logic pdm_clock_pin
);
  logic [7:0] lfsr;
  logic [2:0] phase;

  // data lines take the next lfsr step every cycle, so a line can hold its level; pdm clock stands low when idle
  always_ff @(posedge clock) begin
    if (rst) begin
      lfsr <= 8'h5A;
      phase <= 3'h0;
      pdm_clock_pin <= 1'b0;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      phase <= (!pdm_run || phase == 3'h5) ? 3'h0 : phase + 3'h1;
      if (!pdm_run) begin
        pdm_clock_pin <= 1'b0;
      end else if (phase == 3'h5) begin
        pdm_clock_pin <= !pdm_clock_pin; // six cycles a phase, slow enough to be seen
      end
    end
  end
  assign pins = lfsr[6:0];
endmodule : pin_partner

// ==== verif/testbench.sv ====
// self-checking bench for the pin routing block
`timescale 1ns/1ps
`include "pin_routing_defines.svh"

module testbench;
  logic clock, rst, ce, reg_write, reg_read, dis, pdm_run, chk;
  logic pd, act, fs, bc, d1, d2, pclk;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, m_clk, m_dat, m_pdm;
  logic [6:0] pins;
  logic [3:0] pdm_bit, pdm_valid, e_bit, e_val;
  logic [7:0] hist [0:4];
  logic [31:0] r;
  integer miscompares, checked, seed, k;

  audio_port_pin_routing dut_u (.clock(clock), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .secondary_port_disable(dis), .general_pin_one(pins[0]), .general_pin_two(pins[1]),
    .general_input_pin(pins[2]), .serial_output_pin(pins[3]), .pdm_clock_pin(pclk),
    .primary_frame_sync_pin(pins[4]), .primary_bit_clock_pin(pins[5]),
    .primary_data_pin(pins[6]), .primary_data(pd), .secondary_port_active(act),
    .secondary_frame_sync(fs), .secondary_bit_clock(bc), .secondary_data(d1),
    .secondary_second_data(d2), .pdm_bit(pdm_bit), .pdm_valid(pdm_valid));
  pin_partner partner_u (.clock(clock), .rst(rst), .pdm_run(pdm_run), .pins(pins),
    .pdm_clock_pin(pclk));

  // ----------------------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------------------
  function automatic logic pick(input logic [2:0] c, input logic [7:0] p, input logic a4,
    input logic a5);
    case (c)
      3'h1: pick = p[0];
      3'h2: pick = p[1];
      3'h3: pick = p[2];
      3'h4: pick = a4;
      3'h5: pick = a5;
      default: pick = 1'b0; // reserved codes route nothing
    endcase
  endfunction : pick

  task automatic cmp_out(input logic [13:0] e, input logic [13:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value routed outputs expected %h seen %h", e, g);
    end
  endtask : cmp_out

  task automatic cmp_reg(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value reg_rdata expected %h seen %h", e, g);
    end
  endtask : cmp_reg

  // pins as the design samples them, newest first
  always @(posedge clock) begin
    hist[0] <= {pclk, pins};
    for (int i = 1; i < 5; i++) begin
      hist[i] <= hist[i-1];
    end
  end

  // outputs after an edge reflect pins two samples old; pdm adds the capture flop
  always @(negedge clock) begin : model
    logic [7:0] h, o;
    logic a, x;
    logic [1:0] src;
    h = hist[2];
    o = hist[3];
    a = !dis && m_clk[6:4] inside {3'h1, 3'h2, 3'h3, 3'h5}
      && m_clk[3:1] inside {3'h1, 3'h2, 3'h3, 3'h5};
    e_val = 4'h0;
    for (int l = 0; l < 2; l++) begin
      src = m_pdm[3-2*l -: 2];
      x = pick({1'b0, src}, o, 1'b0, 1'b0);
      for (int c = 0; c < 2; c++) begin
        if (rst || src == 2'b00) begin
          e_bit[2*l+c] = 1'b0;
        end else if (o[7] != hist[4][7] && o[7] == (m_pdm[5-l] ^ c[0])) begin
          e_bit[2*l+c] = x;
          e_val[2*l+c] = 1'b1;
        end
      end
    end
    if (chk) begin
      cmp_out({a, a & pick(m_clk[6:4], h, 1'b0, h[4]), a & pick(m_clk[3:1], h, 1'b0, h[5]),
        a & pick(m_dat[7:5], h, h[3], h[6] & m_clk[7]),
        a & pick(m_dat[4:2], h, h[3], h[6] & m_clk[7]), h[6] & m_clk[7], e_bit, e_val},
        {act, fs, bc, d1, d2, pd, pdm_bit, pdm_valid});
    end
  end

  // ----------------------------------------------------------------------------
  // register port tasks
  // ----------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    case (a)
      `OFS_CLOCK_SOURCE: m_clk = d & `MASK_CLOCK_SOURCE;
      `OFS_DATA_SOURCE: m_dat = d & `MASK_DATA_SOURCE;
      `OFS_PDM_ROUTING: m_pdm = d;
      default: ;
    endcase
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    cmp_reg(e, reg_rdata);
    @(posedge clock);
  endtask : rd

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // a hang is cut short here and counted
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    print_verdict();
  end

  initial begin
    {rst, ce, dis} = 3'b111;
    {reg_write, reg_read, pdm_run, chk} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    {m_clk, m_dat, m_pdm} = {8'h80, 8'h00, 8'h00};
    miscompares = 0;
    checked = 0;
    seed = 78;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd(`OFS_CLOCK_SOURCE, 8'h80);
    rd(`OFS_DATA_SOURCE, 8'h00);
    rd(`OFS_PDM_ROUTING, 8'h00);
    rd(`OFS_CONFIG_FIVE, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'h15, 8'h00);
    $display("test reset values done");
    // software keeps reserved bits at zero; they must still read back zero
    wr(`OFS_CLOCK_SOURCE, 8'hFE);
    rd(`OFS_CLOCK_SOURCE, 8'hFE);
    wr(`OFS_DATA_SOURCE, 8'hFC);
    rd(`OFS_DATA_SOURCE, 8'hFC);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    wr(`OFS_CONFIG_FIVE, 8'hA5);
    rd(`OFS_CONFIG_FIVE, 8'hA5);
    $display("test reserved bits done");
    // every select code, legal and reserved; pdm clock stopped while routing changes
    for (k = 0; k < 24; k++) begin
      pdm_run <= 1'b0;
      chk = 1'b0;
      r = $random(seed);
      repeat (8) @(posedge clock);
      dis <= (k >= 20);
      wr(`OFS_CLOCK_SOURCE, {r[7], k[2:0], k[3] ? r[2:0] : k[2:0], 1'b0});
      wr(`OFS_DATA_SOURCE, {k[2:0] ^ r[10:8], r[4:2], 2'b00});
      wr(`OFS_PDM_ROUTING, {2'b11, r[13:8]});
      rd(`OFS_PDM_ROUTING, {2'b11, r[13:8]});
      repeat (8) @(posedge clock);
      chk = 1'b1;
      pdm_run <= 1'b1;
      repeat (60) @(posedge clock);
    end
    chk = 1'b0;
    $display("test routing done");
    // a write while the enable is low must leave the register untouched
    pdm_run <= 1'b0;
    repeat (8) @(posedge clock);
    ce <= 1'b0;
    wr(`OFS_CONFIG_FIVE, 8'h3C);
    ce <= 1'b1;
    rd(`OFS_CONFIG_FIVE, 8'hA5);
    $display("test clock enable done");
    print_verdict();
  end
endmodule : testbench
